// ### pkg/ntp_pkg.sv
package ntp_pkg;

  // ------------------------------------------------------------
  // Timestamp layout
  // ------------------------------------------------------------
  localparam int STAMP_W = 64;
  localparam int SEC_W = 32;
  localparam int FRAC_W = 32;
  localparam int SEC_LSB = 32;
  localparam int FRAC_LSB = 0;
  localparam int CNT_W = 8;

  // ------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------
  localparam logic [63:0] STAMP_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] STAMP_INVALID = 64'h0000_0000_0000_0000;
  localparam logic [63:0] STAMP_MAX = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [1:0] LEAP_NONE = 2'h0;
  localparam logic [1:0] LEAP_ADD = 2'h1;
  localparam logic [1:0] LEAP_DEL = 2'h2;
  localparam logic [1:0] LEAP_ALARM = 2'h3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam longint CLK_PERIOD_PS = 64'h0000_0000_0000_1388;
  localparam longint PS_PER_SEC = 64'h0000_00E8_D4A5_1000;
  // Fraction step per 5 ns cycle, one LSB is 2^-32 s (about 233 ps)
  localparam logic [31:0] INC_DEFAULT =
    32'((CLK_PERIOD_PS << 32) / PS_PER_SEC);

  // Field bits are numbered from the left: bit 0 is the top bit
  function automatic int msb0(input int field_w, input int n);
    return field_w - 1 - n;
  endfunction

  // Unsigned value halved so a signed operator never sees the top bit set
  function automatic logic signed [64:0] half_u(input logic [63:0] v);
    return $signed({2'b00, v[63:1]});
  endfunction

endpackage

// ### pkg/time_if.sv
`timescale 1ns/10ps
interface time_if;
  logic [63:0] now;
  logic now_valid;
  logic set;
  modport src(output now, output now_valid, output set);
  modport dst(input now, input now_valid, input set);
endinterface

// ### rtl/time_counter.sv
`timescale 1ns/10ps
module time_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic load_en,
  input wire logic [63:0] load_time,
  input wire logic [31:0] inc_frac,
  time_if.src tm
);

  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] frac;
    logic set;
  } cnt_s;

  cnt_s cur_ff;
  cnt_s nxt_cur;
  logic [32:0] frac_sum;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    frac_sum = {1'b0, cur_ff.frac} + {1'b0, inc_frac};
    if (load_en) begin
      nxt_cur.sec = load_time[ntp_pkg::SEC_LSB +: ntp_pkg::SEC_W];
      nxt_cur.frac = load_time[ntp_pkg::FRAC_LSB +: ntp_pkg::FRAC_W];
      nxt_cur.set = 1'b1;
    end else if (cur_ff.set) begin
      // Carry into seconds; seconds roll over freely past 2^32
      nxt_cur.frac = frac_sum[31:0];
      nxt_cur.sec = cur_ff.sec + {31'h0000_0000, frac_sum[32]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{sec: ntp_pkg::STAMP_RST[63:32], frac: ntp_pkg::STAMP_RST[31:0],
                  set: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Unsigned seconds since 1900 start, zero means no valid time
  assign tm.now = {cur_ff.sec, cur_ff.frac};
  assign tm.now_valid = cur_ff.set && (tm.now != ntp_pkg::STAMP_INVALID);
  assign tm.set = cur_ff.set;

endmodule

// ### rtl/stamp_latch.sv
`timescale 1ns/10ps
module stamp_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic evt,
  time_if.dst tm,
  output logic [63:0] stamp,
  output logic stamp_valid,
  output logic [7:0] cap_count
);

  typedef struct packed {
    logic [63:0] stamp;
    logic [7:0] count;
  } lat_s;

  lat_s lat_ff;
  lat_s nxt_lat;

  // ------------------------------------------------------------
  // Capture
  // ------------------------------------------------------------
  always_comb begin
    nxt_lat = lat_ff;
    if (evt) begin
      // Every event takes a fresh copy, retries included
      nxt_lat.stamp = tm.now_valid ? tm.now : ntp_pkg::STAMP_INVALID;
      nxt_lat.count = lat_ff.count + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_ff <= '{stamp: ntp_pkg::STAMP_RST, count: ntp_pkg::CNT_RST};
    end else begin
      lat_ff <= nxt_lat;
    end
  end

  assign stamp = lat_ff.stamp;
  assign stamp_valid = (lat_ff.stamp != ntp_pkg::STAMP_INVALID);
  assign cap_count = lat_ff.count;

endmodule

// ### rtl/ntp_timestamp_capture.sv
`timescale 1ns/10ps
module ntp_timestamp_capture (
  input wire logic clk,
  input wire logic rst,
  input wire logic load_en,
  input wire logic [63:0] load_time,
  input wire logic [31:0] inc_frac,
  input wire logic [1:0] leap_in,
  input wire logic arrive_evt,
  input wire logic depart_evt,
  output logic [63:0] now_time,
  output logic now_valid,
  output logic era_bit,
  output logic [1:0] leap_out,
  output logic [63:0] rx_stamp,
  output logic rx_valid,
  output logic [63:0] tx_stamp,
  output logic tx_valid,
  output logic [7:0] depart_count,
  output logic signed [64:0] rx_tx_delta,
  output logic delta_valid
);

  // ------------------------------------------------------------
  // Types and state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] leap;
    logic signed [64:0] delta;
    logic delta_ok;
    logic era;
  } top_s;

  top_s top_ff;
  top_s nxt_top;

  time_if tm ();

  logic [63:0] rx_q;
  logic [63:0] tx_q;
  logic rx_ok;
  logic tx_ok;
  logic [7:0] rx_cnt;
  logic [7:0] tx_cnt;

  // ------------------------------------------------------------
  // Time counter and capture registers
  // ------------------------------------------------------------
  time_counter u_counter (
    .clk(clk),
    .rst(rst),
    .load_en(load_en),
    .load_time(load_time),
    .inc_frac(inc_frac),
    .tm(tm.src)
  );

  stamp_latch u_rx_latch (
    .clk(clk),
    .rst(rst),
    .evt(arrive_evt),
    .tm(tm.dst),
    .stamp(rx_q),
    .stamp_valid(rx_ok),
    .cap_count(rx_cnt)
  );

  // Departure path: the sender pulses once per attempt on the wire
  stamp_latch u_tx_latch (
    .clk(clk),
    .rst(rst),
    .evt(depart_evt),
    .tm(tm.dst),
    .stamp(tx_q),
    .stamp_valid(tx_ok),
    .cap_count(tx_cnt)
  );

  // ------------------------------------------------------------
  // Leap code, era bit and stamp difference
  // ------------------------------------------------------------
  always_comb begin
    nxt_top = top_ff;
    // Until time is loaded the clock is unsynchronised
    if (tm.set) begin
      nxt_top.leap = leap_in;
    end else begin
      nxt_top.leap = ntp_pkg::LEAP_ALARM;
    end
    // Top seconds bit, i.e. bit 0 of the integer field
    nxt_top.era = tm.now[ntp_pkg::SEC_LSB + ntp_pkg::msb0(ntp_pkg::SEC_W, 0)];
    // Both stamps halved first so the signed subtract cannot misread bit 0
    nxt_top.delta = ntp_pkg::half_u(rx_q) - ntp_pkg::half_u(tx_q);
    nxt_top.delta_ok = rx_ok && tx_ok;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      top_ff <= '{leap: ntp_pkg::LEAP_ALARM, delta: 65'sh0_0000_0000_0000_0000,
                  delta_ok: 1'b0, era: 1'b0};
    end else begin
      top_ff <= nxt_top;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign now_time = tm.now;
  assign now_valid = tm.now_valid;
  assign era_bit = top_ff.era;
  assign leap_out = top_ff.leap;
  assign rx_stamp = rx_q;
  assign rx_valid = rx_ok;
  assign tx_stamp = tx_q;
  assign tx_valid = tx_ok;
  assign depart_count = tx_cnt;
  assign rx_tx_delta = top_ff.delta;
  assign delta_valid = top_ff.delta_ok;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_rx_capture: assert property (
    @(posedge clk) disable iff (rst)
    arrive_evt |=> (rx_stamp == $past(now_time)) && (rx_valid == $past(now_valid))
  ) else $error("arrival stamp does not hold the counter of the event cycle");

  a_tx_recapture: assert property (
    @(posedge clk) disable iff (rst)
    depart_evt |=> (tx_stamp == $past(now_time)) && (depart_count == $past(tx_cnt) + 8'h01)
  ) else $error("departure stamp not refreshed on a retry");

  a_unset_zero: assert property (
    @(posedge clk) disable iff (rst)
    !tm.set |-> (now_time == ntp_pkg::STAMP_INVALID) && !now_valid
  ) else $error("counter moved or read valid before time was loaded");

  a_zero_invalid: assert property (
    @(posedge clk) disable iff (rst)
    (arrive_evt && !now_valid) |=> (rx_stamp == ntp_pkg::STAMP_INVALID) && !rx_valid
  ) else $error("arrival without valid time gave a nonzero stamp");

  a_wrap_invalid: assert property (
    @(posedge clk) disable iff (rst)
    (tm.set && (now_time == ntp_pkg::STAMP_INVALID)) |-> !now_valid
  ) else $error("zero time at wrap reported as valid");

  a_wrap_modulo: assert property (
    @(posedge clk) disable iff (rst)
    (tm.set && !load_en && now_time == ntp_pkg::STAMP_MAX && inc_frac != 32'h0000_0000)
      |=> now_time == {32'h0000_0000, $past(inc_frac) - 32'h0000_0001}
  ) else $error("counter saturated instead of wrapping");

  a_frac_carry: assert property (
    @(posedge clk) disable iff (rst)
    (tm.set && !load_en && ({1'b0, now_time[31:0]} + {1'b0, inc_frac}) > 33'h0_FFFF_FFFF)
      |=> now_time[63:32] == $past(now_time[63:32]) + 32'h0000_0001
  ) else $error("fraction overflow did not carry into seconds");

  a_load_time: assert property (
    @(posedge clk) disable iff (rst)
    load_en |=> (now_time[63:32] == $past(load_time[63:32])) &&
                (now_time[31:0] == $past(load_time[31:0])) ##1 tm.set
  ) else $error("loaded time not placed as seconds over fraction");

  a_leap_alarm: assert property (
    @(posedge clk) disable iff (rst)
    !tm.set |=> leap_out == ntp_pkg::LEAP_ALARM
  ) else $error("unsynchronised clock did not raise the alarm leap code");

  a_leap_pass: assert property (
    @(posedge clk) disable iff (rst)
    tm.set |=> leap_out == $past(leap_in)
  ) else $error("leap code not passed on");

  a_delta_sign: assert property (
    @(posedge clk) disable iff (rst)
    ($past(rx_stamp) >= $past(tx_stamp)) |-> !rx_tx_delta[64]
  ) else $error("unsigned stamps gave a negative difference");

  // ------------------------------------------------------------
  // Holding, counting, capture, era, leap and difference checks
  // ------------------------------------------------------------
  a_rx_count: assert property (
    @(posedge clk) disable iff (rst)
    arrive_evt |=> rx_cnt == $past(rx_cnt) + 8'h01
  ) else $error("arrival count did not step on an event");

  a_rx_count_hold: assert property (
    @(posedge clk) disable iff (rst)
    !arrive_evt |=> rx_cnt == $past(rx_cnt)
  ) else $error("arrival count moved without an event");

  // A stamp stands until the next event of its own kind
  a_rx_hold: assert property (
    @(posedge clk) disable iff (rst)
    !arrive_evt |=> rx_stamp == $past(rx_stamp)
  ) else $error("arrival stamp changed without an event");

  a_tx_hold: assert property (
    @(posedge clk) disable iff (rst)
    !depart_evt |=> (tx_stamp == $past(tx_stamp)) &&
                    (depart_count == $past(depart_count))
  ) else $error("departure stamp or count changed without an event");

  a_tx_valid: assert property (
    @(posedge clk) disable iff (rst)
    depart_evt |=> tx_valid == $past(now_valid)
  ) else $error("departure valid does not follow the counter valid");

  a_tx_invalid: assert property (
    @(posedge clk) disable iff (rst)
    (depart_evt && !now_valid) |=> (tx_stamp == ntp_pkg::STAMP_INVALID) && !tx_valid
  ) else $error("departure without valid time gave a nonzero stamp");

  a_both_equal: assert property (
    @(posedge clk) disable iff (rst)
    (arrive_evt && depart_evt) |=> rx_stamp == tx_stamp
  ) else $error("coinciding events captured different stamps");

  // Full 64-bit step: seconds pass all ones and restart, never stick
  a_count_step: assert property (
    @(posedge clk) disable iff (rst)
    (tm.set && !load_en)
      |=> now_time == $past(now_time) + {32'h0000_0000, $past(inc_frac)}
  ) else $error("counter did not advance by the increment");

  // The counter stays at zero until time is first loaded
  a_unset_hold: assert property (
    @(posedge clk) disable iff (rst)
    (!tm.set && !load_en) |=> now_time == ntp_pkg::STAMP_INVALID
  ) else $error("counter ran before time was loaded");

  a_set_sticky: assert property (
    @(posedge clk) disable iff (rst)
    tm.set |=> tm.set
  ) else $error("clock lost its set state without a reset");

  a_load_sets: assert property (
    @(posedge clk) disable iff (rst)
    load_en |=> tm.set &&
                (now_valid == ($past(load_time) != ntp_pkg::STAMP_INVALID))
  ) else $error("load did not set the clock or gave a wrong valid");

  a_frac_nocarry: assert property (
    @(posedge clk) disable iff (rst)
    (tm.set && !load_en && ({1'b0, now_time[31:0]} + {1'b0, inc_frac}) <= 33'h0_FFFF_FFFF)
      |=> now_time[63:32] == $past(now_time[63:32])
  ) else $error("seconds moved without a fraction overflow");

  // Era bit lags the counter by one cycle, so it is compared against the past
  a_era_track: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> era_bit == $past(now_time[63])
  ) else $error("era bit does not follow the top seconds bit");

  a_leap_unset: assert property (
    @(posedge clk) disable iff (rst)
    !tm.set |-> leap_out == ntp_pkg::LEAP_ALARM
  ) else $error("leap code left alarm while the clock is unset");

  a_delta_ok: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> delta_valid == ($past(rx_valid) && $past(tx_valid))
  ) else $error("difference valid does not follow both stamps");

  // Halved operands leave headroom, so the sign bit of the difference is exact
  a_delta_neg: assert property (
    @(posedge clk) disable iff (rst)
    ($past(rx_stamp[63:1]) < $past(tx_stamp[63:1])) |-> rx_tx_delta[64]
  ) else $error("earlier arrival gave a non-negative difference");

  a_delta_equal: assert property (
    @(posedge clk) disable iff (rst)
    ($past(rx_stamp) == $past(tx_stamp)) |-> rx_tx_delta == '0
  ) else $error("equal stamps gave a nonzero difference");

  // The single all-zero step at the wrap captures as invalid, like no time
  a_wrap_capture: assert property (
    @(posedge clk) disable iff (rst)
    (arrive_evt && tm.set && (now_time == ntp_pkg::STAMP_INVALID)) |=> !rx_valid
  ) else $error("arrival at the wrap instant read as valid");

endmodule

// ### tb/msg_path_model.sv
`timescale 1ns/10ps
module msg_path_model (
  input wire logic clk,
  input wire logic rx_go,
  input wire logic tx_go,
  input wire logic tx_retry,
  output logic arrive_evt,
  output logic depart_evt
);
  logic retry_ff = 1'b0;
  initial begin
    arrive_evt = 1'b0;
    depart_evt = 1'b0;
  end
  // Events are one-cycle pulses; a retry resends the departure one cycle later
  always @(negedge clk) begin
    arrive_evt <= rx_go;
    depart_evt <= tx_go | retry_ff;
    retry_ff <= tx_go & tx_retry;
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  typedef struct {
    logic [63:0] t;
    logic [31:0] inc;
    logic [63:0] nxt;
    logic v0;
    logic v1;
  } row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic load_en = 1'b0;
  logic [63:0] load_time = 64'h0000_0000_0000_0000;
  logic [31:0] inc_frac = 32'h0000_0015;
  logic [1:0] leap_in = 2'h0;
  logic rx_go = 1'b0;
  logic tx_go = 1'b0;
  logic tx_retry = 1'b0;
  logic arrive_evt, depart_evt, now_valid, era_bit, rx_valid, tx_valid, delta_valid;
  logic [63:0] now_time, rx_stamp, tx_stamp, tb_t;
  logic [1:0] leap_out;
  logic [7:0] depart_count;
  logic signed [64:0] rx_tx_delta;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  row_s rows [5];

  always #2.5 clk = ~clk;

  msg_path_model msg_path_model_inst (.clk(clk), .rx_go(rx_go), .tx_go(tx_go),
    .tx_retry(tx_retry), .arrive_evt(arrive_evt), .depart_evt(depart_evt));

  ntp_timestamp_capture ntp_timestamp_capture_inst (.clk(clk), .rst(rst),
    .load_en(load_en), .load_time(load_time), .inc_frac(inc_frac), .leap_in(leap_in),
    .arrive_evt(arrive_evt), .depart_evt(depart_evt), .now_time(now_time),
    .now_valid(now_valid), .era_bit(era_bit), .leap_out(leap_out), .rx_stamp(rx_stamp),
    .rx_valid(rx_valid), .tx_stamp(tx_stamp), .tx_valid(tx_valid),
    .depart_count(depart_count), .rx_tx_delta(rx_tx_delta), .delta_valid(delta_valid));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [64:0] e, input logic [64:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
      err_count++;
    end
  endtask

  task automatic load(input logic [63:0] t);
    @(negedge clk);
    load_en = 1'b1;
    load_time = t;
    @(negedge clk);
    load_en = 1'b0;
  endtask

  // Bounded run: the whole sequence needs well under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    rows[0] = '{64'h0000_0001_0000_0000, 32'h0000_0015, 64'h0000_0001_0000_0015, 1'b1, 1'b1};
    rows[1] = '{64'h0000_0001_FFFF_FFF0, 32'h0000_0020, 64'h0000_0002_0000_0010, 1'b1, 1'b1};
    rows[2] = '{64'hFFFF_FFFF_FFFF_FFFF, 32'h0000_0001, 64'h0000_0000_0000_0000, 1'b1, 1'b0};
    rows[3] = '{64'h0000_0000_0000_0000, 32'h0000_0015, 64'h0000_0000_0000_0015, 1'b0, 1'b1};
    rows[4] = '{64'h8000_0000_1234_5678, 32'h0000_0015, 64'h8000_0000_1234_568D, 1'b1, 1'b1};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_word("now_time", 65'h0, 65'(now_time));
    chk_bit("now_valid", 1'b0, now_valid);
    chk_word("leap_out", 65'h3, 65'(leap_out));
    // Arrival and departure before any time is loaded give invalid stamps
    rx_go <= 1'b1;
    tx_go <= 1'b1;
    @(negedge clk);
    rx_go <= 1'b0;
    tx_go <= 1'b0;
    @(negedge clk);
    chk_word("rx_stamp", 65'h0, 65'(rx_stamp));
    chk_bit("rx_valid", 1'b0, rx_valid);
    chk_word("tx_stamp", 65'h0, 65'(tx_stamp));
    chk_bit("tx_valid", 1'b0, tx_valid);
    foreach (rows[i]) begin
      inc_frac = rows[i].inc;
      load(rows[i].t);
      chk_word("now_time", 65'(rows[i].t), 65'(now_time));
      chk_bit("now_valid", rows[i].v0, now_valid);
      @(negedge clk);
      chk_word("now_time", 65'(rows[i].nxt), 65'(now_time));
      chk_bit("now_valid", rows[i].v1, now_valid);
      chk_bit("era_bit", rows[i].t[63], era_bit);
    end
    for (int c = 0; c < 4; c++) begin
      leap_in = 2'(c);
      @(negedge clk);
      @(negedge clk);
      chk_word("leap_out", 65'(c), 65'(leap_out));
    end
    // Coinciding arrival and departure, then a retried departure
    inc_frac = 32'h0000_0015;
    tb_t = 64'h0000_0010_0000_0000;
    load(tb_t);
    rx_go <= 1'b1;
    tx_go <= 1'b1;
    tx_retry <= 1'b1;
    @(negedge clk);
    rx_go <= 1'b0;
    tx_go <= 1'b0;
    tx_retry <= 1'b0;
    @(negedge clk);
    chk_word("rx_stamp", 65'(tb_t + 64'h15), 65'(rx_stamp));
    chk_word("tx_stamp", 65'(tb_t + 64'h15), 65'(tx_stamp));
    chk_bit("rx_valid", 1'b1, rx_valid);
    chk_bit("tx_valid", 1'b1, tx_valid);
    @(negedge clk);
    chk_word("tx_stamp", 65'(tb_t + 64'h2A), 65'(tx_stamp));
    chk_word("depart_count", 65'h3, 65'(depart_count));
    chk_word("rx_tx_delta", 65'h0, 65'(rx_tx_delta));
    chk_bit("delta_valid", 1'b1, delta_valid);
    @(negedge clk);
    chk_word("rx_tx_delta", 65'((tb_t + 64'h15) >> 1) - 65'((tb_t + 64'h2A) >> 1),
      65'(rx_tx_delta));
    chk_word("rx_stamp", 65'(tb_t + 64'h15), 65'(rx_stamp));
    // Reset in mid-run clears the clock and the departure stamp, count and valid
    rst = 1'b1;
    @(negedge clk);
    chk_word("now_time", 65'h0, 65'(now_time));
    chk_word("tx_stamp", 65'h0, 65'(tx_stamp));
    chk_word("depart_count", 65'h0, 65'(depart_count));
    chk_bit("tx_valid", 1'b0, tx_valid);
    rst = 1'b0;
    @(negedge clk);
    chk_word("now_time", 65'h0, 65'(now_time));
    chk_bit("now_valid", 1'b0, now_valid);
    chk_word("leap_out", 65'h3, 65'(leap_out));
    wrap_up();
  end
endmodule
